// *** rtl/aafc_ctrl.v ***
// Accumulate, format and reference control for a successive-approximation converter.
// Assumes a byte-wide special-function register port synchronous to clk_sys and a
// converter core that answers each conversion request with one conv_done pulse.
// Burst mode enable comes from a control register outside this block.
//
// Behaviour
// - Accumulator config bit 7 set enables twelve-bit mode, clear disables it.
// - Burst off: result holds latest conversion, or running sum when accumulate set.
// - Writing zero to both result bytes clears the sum; accumulation restarts.
// - Accumulate-enable bit is write-only and always reads zero.
// - Shift-justify 000-011 right justify shifted 0-3; 100 left justify unshifted.
// - In burst mode repeat codes 000-101 select 1,4,8,16,32,64 summed conversions.
// - Reference control bit 5 selects ground pin (0) or analog-ground pin (1).
// - Bits 4:3 select external, supply, 1.8 V digital or 1.65 V internal reference.
// - Reference control bit 2 enables the internal temperature sensor.
// - Reference control bits 7:6 and 1:0 read zero and ignore writes.
`timescale 1ns/1ns
`include "aafc_defs.vh"

module aafc_ctrl #(
    parameter SUM_W = 16
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             sys_rst,
    // Special-function register port
    input  wire [7:0]       sfr_addr,
    input  wire             sfr_wr,
    input  wire             sfr_rd,
    input  wire [7:0]       sfr_wdata,
    output reg  [7:0]       sfr_rdata,
    // Converter core
    input  wire             burst_mode_en,
    input  wire             conv_start,
    output reg              conv_req,
    input  wire             conv_done,
    input  wire [11:0]      conv_data,
    output reg              burst_done,
    // Mode and reference controls
    output wire             twelve_bit_mode_en,
    output wire             ground_ref_sel,
    output wire [1:0]       voltage_ref_sel,
    output wire             temp_sensor_en
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_REQ  = 3'h2;
    localparam [2:0] ST_WAIT = 3'h4;

    reg  [7:0]       acc_cfg;
    reg  [7:0]       ref_ctrl;
    reg  [SUM_W-1:0] result;
    reg  [SUM_W-1:0] burst_sum;
    // Seven bits hold the longest burst of 64 conversions
    reg  [6:0]       burst_left;
    reg  [2:0]       state;
    reg  [2:0]       next_state;

    wire             accumulate_en      = acc_cfg[`AAFC_ACC_EN];
    wire [2:0]       shift_justify_sel  = acc_cfg[`AAFC_SJ_HI:`AAFC_SJ_LO];
    wire [2:0]       burst_repeat_count = acc_cfg[`AAFC_RPT_HI:`AAFC_RPT_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    // Result bytes are writable so software can clear a running sum
    wire wr_cfg    = sfr_wr && (sfr_addr == `AAFC_ADDR_ACC_CFG);
    wire wr_ref    = sfr_wr && (sfr_addr == `AAFC_ADDR_REF_CTRL);
    wire wr_res_lo = sfr_wr && (sfr_addr == `AAFC_ADDR_RESULT_LO);
    wire wr_res_hi = sfr_wr && (sfr_addr == `AAFC_ADDR_RESULT_HI);

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            acc_cfg  <= `AAFC_ACC_CFG_RESET;
            ref_ctrl <= `AAFC_REF_CTRL_RESET;
        end else begin
            // Accumulate enable is stored although it reads back as zero
            if (wr_cfg)
                acc_cfg <= sfr_wdata;
            if (wr_ref)
                ref_ctrl <= sfr_wdata & `AAFC_REF_WR_MASK;
        end
    end

    assign twelve_bit_mode_en = acc_cfg[`AAFC_TWELVE_BIT];
    assign ground_ref_sel     = ref_ctrl[`AAFC_GND_REF];
    assign voltage_ref_sel    = ref_ctrl[`AAFC_VREF_HI:`AAFC_VREF_LO];
    assign temp_sensor_en     = ref_ctrl[`AAFC_TEMP_EN];

    ////////////////////////////////////////////////////////////////////////////
    // Sample width and burst length

    // In ten-bit mode the two top sample bits are not part of the conversion
    wire [SUM_W-1:0] sample = twelve_bit_mode_en ? {{(SUM_W-12){1'b0}}, conv_data}
                                                 : {{(SUM_W-10){1'b0}}, conv_data[9:0]};

    function [6:0] repeat_len;
        input [2:0] code;
        begin
            case (code)
                3'h0:    repeat_len = 7'h01;
                3'h1:    repeat_len = 7'h04;
                3'h2:    repeat_len = 7'h08;
                3'h3:    repeat_len = 7'h10;
                3'h4:    repeat_len = 7'h20;
                3'h5:    repeat_len = 7'h40;
                // Reserved codes are never programmed; treat as one conversion
                default: repeat_len = 7'h01;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencer

    // Outside burst the sequencer stays idle and the trigger passes straight through
    wire single_start = (state == ST_IDLE) && !burst_mode_en && conv_start;
    wire single_done  = (state == ST_IDLE) && !burst_mode_en && conv_done;
    wire burst_start  = (state == ST_IDLE) && burst_mode_en && conv_start;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (burst_mode_en && conv_start)
                    next_state = ST_REQ;
            end
            ST_REQ: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done)
                    next_state = (burst_left == 7'h01) ? ST_IDLE : ST_REQ;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    wire burst_last = (state == ST_WAIT) && conv_done && (burst_left == 7'h01);

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            burst_sum  <= {SUM_W{1'b0}};
            burst_left <= 7'h00;
            conv_req   <= 1'b0;
            burst_done <= 1'b0;
        end else begin
            state      <= next_state;
            // A start that arrives while a burst runs is dropped, not queued
            conv_req   <= (next_state == ST_REQ) || single_start;
            burst_done <= burst_last;
            if (burst_start) begin
                burst_sum  <= {SUM_W{1'b0}};
                burst_left <= repeat_len(burst_repeat_count);
            end else if ((state == ST_WAIT) && conv_done) begin
                burst_sum  <= burst_sum + sample;
                burst_left <= burst_left - 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result register pair

    // A software write lands first; with accumulate set and burst off, a conversion in the same cycle adds onto it,
    // so a clear never loses the sample that arrives with it
    wire [SUM_W-1:0] result_base = {wr_res_hi ? sfr_wdata : result[15:8],
                                    wr_res_lo ? sfr_wdata : result[7:0]};

    // The sum is not saturated: a long twelve-bit burst wraps at 16 bits
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            result <= {SUM_W{1'b0}};
        end else if (burst_last) begin
            result <= burst_sum + sample;
        end else if (single_done) begin
            result <= accumulate_en ? (result_base + sample) : sample;
        end else begin
            result <= result_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read formatting

    // Shifts act on the read path only; the stored sum keeps every bit
    // Left justification aligns a single sample's top bit with bit 15; it is
    // meaningless for accumulated sums, which overflow the shift
    wire [3:0]       lj_shift  = twelve_bit_mode_en ? `AAFC_LJ_SHIFT_12 : `AAFC_LJ_SHIFT_10;
    reg  [SUM_W-1:0] formatted;

    always @* begin
        case (shift_justify_sel)
            3'h0:          formatted = result;
            3'h1:          formatted = result >> 1;
            3'h2:          formatted = result >> 2;
            3'h3:          formatted = result >> 3;
            `AAFC_SJ_LEFT: formatted = result << lj_shift;
            // Reserved codes read back unformatted
            default:       formatted = result;
        endcase
    end

    // Read data is registered and holds until the next read strobe
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `AAFC_ADDR_ACC_CFG:   sfr_rdata <= acc_cfg & ~(8'h01 << `AAFC_ACC_EN);
                `AAFC_ADDR_REF_CTRL:  sfr_rdata <= ref_ctrl;
                `AAFC_ADDR_RESULT_LO: sfr_rdata <= formatted[7:0];
                `AAFC_ADDR_RESULT_HI: sfr_rdata <= formatted[15:8];
                default:              sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// *** common/aafc_defs.vh ***
// Constants for the converter accumulate, format and reference control block.
// Assumes an 8-bit special-function register space with byte-wide accesses.
`ifndef AAFC_DEFS_VH
`define AAFC_DEFS_VH

// Register addresses in the special-function register space
`define AAFC_ADDR_ACC_CFG     8'hBA
`define AAFC_ADDR_REF_CTRL    8'hD1
`define AAFC_ADDR_RESULT_LO   8'hC4
`define AAFC_ADDR_RESULT_HI   8'hC5

// Reset values
`define AAFC_ACC_CFG_RESET    8'h00
`define AAFC_REF_CTRL_RESET   8'h18

// Accumulator configuration fields
`define AAFC_TWELVE_BIT       7
`define AAFC_ACC_EN           6
`define AAFC_SJ_HI            5
`define AAFC_SJ_LO            3
`define AAFC_RPT_HI           2
`define AAFC_RPT_LO           0

// Reference control fields
`define AAFC_GND_REF          5
`define AAFC_VREF_HI          4
`define AAFC_VREF_LO          3
`define AAFC_TEMP_EN          2
`define AAFC_REF_WR_MASK      8'h3C

// Shift and justify codes
`define AAFC_SJ_RIGHT_MAX     3'h3
`define AAFC_SJ_LEFT          3'h4

// Left-justify shift amounts for 10-bit and 12-bit samples
`define AAFC_LJ_SHIFT_10      4'h6
`define AAFC_LJ_SHIFT_12      4'h4

`endif

// *** bench/aafc_ctrl_props.sv ***
// Port-level assertions for the converter control block.
// Assumes it is bound to every aafc_ctrl instance.
`timescale 1ns/1ns
`include "aafc_defs.vh"
module aafc_ctrl_props (
    // Clock, reset and register port
    input logic       clk_sys,
    input logic       sys_rst,
    input logic [7:0] sfr_addr,
    input logic       sfr_wr,
    input logic       sfr_rd,
    input logic [7:0] sfr_wdata,
    input logic [7:0] sfr_rdata,
    // Converter side and controls
    input logic       burst_mode_en,
    input logic       conv_req,
    input logic       burst_done,
    input logic       twelve_bit_mode_en,
    input logic       ground_ref_sel,
    input logic [1:0] voltage_ref_sel,
    input logic       temp_sensor_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire acc_wr = sfr_wr && sfr_addr == `AAFC_ADDR_ACC_CFG;
    wire ref_wr = sfr_wr && sfr_addr == `AAFC_ADDR_REF_CTRL;
    wire acc_rd = sfr_rd && !sfr_wr && sfr_addr == `AAFC_ADDR_ACC_CFG;
    wire ref_rd = sfr_rd && !sfr_wr && sfr_addr == `AAFC_ADDR_REF_CTRL;
    twelve_load_a: assert property (acc_wr |=> twelve_bit_mode_en == $past(sfr_wdata[7]))
        else $error("twelve-bit enable not loaded");
    twelve_hold_a: assert property (!acc_wr |=> $stable(twelve_bit_mode_en))
        else $error("twelve-bit enable moved without a write");
    gnd_load_a: assert property (ref_wr |=> ground_ref_sel == $past(sfr_wdata[5]))
        else $error("ground select not loaded");
    vref_load_a: assert property (ref_wr |=> voltage_ref_sel == $past(sfr_wdata[4:3]))
        else $error("reference select not loaded");
    temp_load_a: assert property (ref_wr |=> temp_sensor_en == $past(sfr_wdata[2]))
        else $error("sensor enable not loaded");
    acc_read_a: assert property (acc_rd |=> sfr_rdata[7:6] == {$past(twelve_bit_mode_en), 1'b0})
        else $error("config read wrong");
    ref_read_a: assert property (ref_rd |=> sfr_rdata == {2'b00, $past(ground_ref_sel),
        $past(voltage_ref_sel), $past(temp_sensor_en), 2'b00}) else $error("reference read wrong");
    req_pulse_a: assert property (conv_req |=> !conv_req)
        else $error("request longer than one cycle");
    done_pulse_a: assert property (burst_done |-> burst_mode_en ##1 !burst_done)
        else $error("burst done malformed");
endmodule
bind aafc_ctrl aafc_ctrl_props chk_u (.*);

// *** bench/aafc_ctrl_tb.sv ***
// Self-checking bench for the converter control block.
// Assumes the bench answers each conversion request one cycle after seeing it.
`timescale 1ns/1ns
`include "aafc_defs.vh"
module aafc_ctrl_tb;
    logic        clk_sys = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, burst_mode_en = 0;
    logic        conv_start = 0, conv_done = 0, conv_req, burst_done;
    logic        twelve_bit_mode_en, ground_ref_sel, temp_sensor_en;
    logic [1:0]  voltage_ref_sel;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, d;
    logic [11:0] conv_data = 0;
    int          bad_count = 0, check_count = 0;
    int          cnt [6] = '{1, 4, 8, 16, 32, 64};
    aafc_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .burst_mode_en(burst_mode_en),
        .conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
        .burst_done(burst_done), .twelve_bit_mode_en(twelve_bit_mode_en), .ground_ref_sel(ground_ref_sel),
        .voltage_ref_sel(voltage_ref_sel), .temp_sensor_en(temp_sensor_en));
    initial forever #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= v;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        // Let the write settle before any pin is looked at
        @(negedge clk_sys);
    endtask
    // Read data is sampled mid-cycle so the launching edge has settled
    task automatic rd(logic [7:0] a);
        @(posedge clk_sys);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        @(negedge clk_sys);
        d = sfr_rdata;
    endtask
    task automatic res(logic [15:0] exp);
        logic [7:0] lo;
        rd(`AAFC_ADDR_RESULT_LO);
        lo = d;
        rd(`AAFC_ADDR_RESULT_HI);
        check("result", {d, lo}, exp);
    endtask
    task automatic wait_for(bit sel);
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while ((sel ? burst_done : conv_req) !== 1'b1 && i < 300);
        if ((sel ? burst_done : conv_req) !== 1'b1) begin
            bad_count++;
            conclude();
        end
    endtask
    task automatic conv(int n, logic [11:0] v);
        @(posedge clk_sys);
        conv_start <= 1'b1;
        @(posedge clk_sys);
        conv_start <= 1'b0;
        repeat (n) begin
            wait_for(0);
            conv_done <= 1'b1;
            conv_data <= v;
            @(posedge clk_sys);
            conv_done <= 1'b0;
        end
        if (burst_mode_en) wait_for(1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`AAFC_ADDR_ACC_CFG); check("cfg reset", d, 8'h00);
        rd(`AAFC_ADDR_REF_CTRL); check("ref reset", d, 8'h18);
        wr(`AAFC_ADDR_REF_CTRL, 8'hFF); rd(`AAFC_ADDR_REF_CTRL); check("ref ones", d, 8'h3C);
        check("ref pins", {ground_ref_sel, voltage_ref_sel, temp_sensor_en}, 4'hF);
        wr(`AAFC_ADDR_REF_CTRL, 8'h08); check("ref sel", {ground_ref_sel, voltage_ref_sel, temp_sensor_en}, 4'h2);
        wr(`AAFC_ADDR_ACC_CFG, 8'hC0); rd(`AAFC_ADDR_ACC_CFG); check("cfg read", d, 8'h80);
        check("twelve on", twelve_bit_mode_en, 1);
    endtask
    task automatic t_single();
        wr(`AAFC_ADDR_ACC_CFG, 8'h00); conv(1, 12'h100); conv(1, 12'hC05); res(16'h0005);
        wr(`AAFC_ADDR_ACC_CFG, 8'h40); conv(1, 12'h010); res(16'h0015);
        wr(`AAFC_ADDR_RESULT_LO, 0); wr(`AAFC_ADDR_RESULT_HI, 0);
        conv(1, 12'h010); conv(1, 12'h018); res(16'h0028);
    endtask
    task automatic t_format();
        for (int c = 0; c < 4; c++) begin
            wr(`AAFC_ADDR_ACC_CFG, 8'(c << 3)); res(16'h0028 >> c);
        end
        wr(`AAFC_ADDR_ACC_CFG, 8'h20); res(16'h0A00);
        wr(`AAFC_ADDR_ACC_CFG, 8'hA0); res(16'h0280);
    endtask
    task automatic t_burst();
        burst_mode_en <= 1'b1;
        for (int r = 0; r < 6; r++) begin
            wr(`AAFC_ADDR_RESULT_LO, 0); wr(`AAFC_ADDR_RESULT_HI, 0);
            wr(`AAFC_ADDR_ACC_CFG, 8'(r)); conv(cnt[r], 12'h003); res(16'(3 * cnt[r]));
        end
        burst_mode_en <= 1'b0;
        wr(`AAFC_ADDR_ACC_CFG, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_single();
        t_format();
        t_burst();
        conclude();
    end
endmodule
